// [iph_pkg.sv]
// iph_pkg: constants, enumerations and helpers for the instruction phase
// pipeline. assumes a single 200 MHz core clock and a 14-bit program space.
package iph_pkg;

  localparam int PC_W = 14;
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int OSC_N = 3;

  // instruction word fields
  localparam int CLS_HI = 15;
  localparam int CLS_LO = 14;
  localparam int OP_HI = 13;
  localparam int OP_LO = 10;
  localparam int IMM_HI = 7;
  localparam int TGT_HI = 13;

  // reset values
  localparam logic [PC_W-1:0] RESET_VEC = 14'h0000;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

  // oscillator inputs, as bit positions in the raw oscillator vector
  localparam int OSC_FAST_IDX = 0;
  localparam int OSC_SLOW_IDX = 1;
  localparam int OSC_XTAL_IDX = 2;

  // system clock source select codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } iph_phase_e;

  typedef enum logic [2:0] {
    EX_DUMMY = 3'h1,
    EX_RUN = 3'h2,
    EX_EXT2 = 3'h4
  } iph_exec_e;

  typedef enum logic [1:0] {
    CL_NORM = 2'h0,
    CL_EXT = 2'h1,
    CL_BRANCH = 2'h2,
    CL_SKIP = 2'h3
  } iph_class_e;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
    OP_AND = 4'h4, OP_OR = 4'h5, OP_XOR = 4'h6, OP_CPL = 4'h7,
    OP_RL = 4'h8, OP_RR = 4'h9, OP_RLC = 4'hA, OP_RRC = 4'hB,
    OP_INC = 4'hC, OP_DEC = 4'hD, OP_LOAD = 4'hE, OP_PASS = 4'hF
  } iph_alu_op_e;

  function automatic iph_class_e iph_class_f(input logic [INSTR_W-1:0] w);
    return iph_class_e'(w[CLS_HI:CLS_LO]);
  endfunction : iph_class_f

  function automatic iph_alu_op_e iph_op_f(input logic [INSTR_W-1:0] w);
    return iph_alu_op_e'(w[OP_HI:OP_LO]);
  endfunction : iph_op_f

endpackage : iph_pkg

// [iph_alu.sv]
// iph_alu: 8-bit combinational alu working against the accumulator.
// assumes the caller registers the result and the carry.
`timescale 1ns/10ps
module iph_alu (
  input wire iph_pkg::iph_alu_op_e i_op,
  input wire logic [iph_pkg::DATA_W-1:0] i_a,
  input wire logic [iph_pkg::DATA_W-1:0] i_b,
  input wire logic i_carry,
  output logic [iph_pkg::DATA_W-1:0] o_result,
  output logic o_carry,
  output logic o_zero
);
  import iph_pkg::*;

  logic [DATA_W:0] sum;

  always_comb begin // [RL10]
    sum = {1'b0, i_a};
    o_result = i_a;
    o_carry = i_carry;
    case (i_op)
      OP_ADD, OP_ADC: begin
        sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry & (i_op == OP_ADC)};
        o_result = sum[DATA_W-1:0];
        o_carry = sum[DATA_W];
      end
      OP_SUB, OP_SBC: begin
        // carry set means no borrow
        sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, ~i_carry & (i_op == OP_SBC)};
        o_result = sum[DATA_W-1:0];
        o_carry = ~sum[DATA_W];
      end
      OP_AND: o_result = i_a & i_b;
      OP_OR: o_result = i_a | i_b;
      OP_XOR: o_result = i_a ^ i_b;
      OP_CPL: o_result = ~i_a;
      OP_RL: o_result = {i_a[DATA_W-2:0], i_a[DATA_W-1]};
      OP_RR: o_result = {i_a[0], i_a[DATA_W-1:1]};
      OP_RLC: begin
        o_result = {i_a[DATA_W-2:0], i_carry};
        o_carry = i_a[DATA_W-1];
      end
      OP_RRC: begin
        o_result = {i_carry, i_a[DATA_W-1:1]};
        o_carry = i_a[0];
      end
      OP_INC: o_result = i_a + 8'h01;
      OP_DEC: o_result = i_a - 8'h01;
      OP_LOAD: o_result = i_b;
      default: o_result = i_a;
    endcase
    o_zero = (o_result == 8'h00);
  end

endmodule : iph_alu

// [iph_clk_sel.sv]
// iph_clk_sel: picks the system clock source and turns its rising edges
// into one-cycle ticks. assumes every oscillator runs at most a quarter of
// i_clk, and that the select input comes from the i_clk domain.
`timescale 1ns/10ps
module iph_clk_sel (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_clk_src,
  input wire logic i_fast_irc_osc,
  input wire logic i_slow_irc_osc,
  input wire logic i_ext_xtal_osc,
  output logic o_sys_tick
);
  import iph_pkg::*;

  logic [OSC_N-1:0] osc_raw;
  logic [OSC_N-1:0] s1_reg, s1_next;
  logic [OSC_N-1:0] s2_reg, s2_next;
  logic [OSC_N-1:0] s3_reg, s3_next;
  logic [OSC_N-1:0] osc_rise;
  logic tick_reg, tick_next;

  assign osc_raw[OSC_FAST_IDX] = i_fast_irc_osc;
  assign osc_raw[OSC_SLOW_IDX] = i_slow_irc_osc;
  assign osc_raw[OSC_XTAL_IDX] = i_ext_xtal_osc;

  // switching source mid-cycle may shorten one phase; no glitch guard
  always_comb begin // [RL2]
    s1_next = osc_raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
    osc_rise = s2_reg & ~s3_reg;
    case (i_clk_src)
      SRC_SLOW: tick_next = osc_rise[OSC_SLOW_IDX];
      SRC_XTAL: tick_next = osc_rise[OSC_XTAL_IDX];
      SRC_FAST: tick_next = osc_rise[OSC_FAST_IDX];
      default: tick_next = osc_rise[OSC_FAST_IDX];
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // reset high: an oscillator already high at release is no rise
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
      s3_reg <= 3'h7;
      tick_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      tick_reg <= tick_next;
    end
  end

  assign o_sys_tick = tick_reg;

endmodule : iph_clk_sel

// [iph_pipeline.sv]
// iph_pipeline: four-phase instruction cycle sequencer with a two-stage
// fetch/execute pipeline, accumulator and alu.
// assumes a synchronous program memory: data valid the cycle after
// o_pm_rd and held until the next read.
//
// Contract
// RL1 - four non-overlapping phases from system clock
// RL2 - system clock from one of three oscillators
// RL3 - first phase: bump counter, start fetch
// RL4 - decode and execute in phases two to four
// RL5 - four phases make one instruction cycle
// RL6 - fetch next while executing current
// RL7 - standard one cycle, extended two cycles
// RL8 - counter-changing instructions take one extra cycle
// RL9 - branch: fetch target, then execute branch
// RL10 - eight-bit alu through the accumulator
// RL11 - taken skip or branch: discard, dummy cycle
// RL12 - reset: phase one, no valid prefetch
`timescale 1ns/10ps
module iph_pipeline (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_clk_src,
  input wire logic i_fast_irc_osc,
  input wire logic i_slow_irc_osc,
  input wire logic i_ext_xtal_osc,
  input wire logic [iph_pkg::INSTR_W-1:0] i_pm_data,
  output logic [iph_pkg::PC_W-1:0] o_pm_addr,
  output logic o_pm_rd,
  output logic [3:0] o_phase,
  output logic [iph_pkg::PC_W-1:0] o_pc,
  output logic [iph_pkg::DATA_W-1:0] o_acc,
  output logic o_carry,
  output logic o_instr_done,
  output logic o_dummy
);
  import iph_pkg::*;

  logic rst_s1_reg;
  logic rst_n_reg;
  logic tick;

  iph_phase_e phase_reg, phase_next;
  iph_exec_e exec_reg, exec_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] pm_addr_reg, pm_addr_next;
  logic [PC_W-1:0] tgt_reg, tgt_next;
  logic pm_rd_reg, pm_rd_next;
  logic boot_reg, boot_next;
  logic [INSTR_W-1:0] pf_reg, pf_next;
  logic pf_valid_reg, pf_valid_next;
  logic [INSTR_W-1:0] ir_reg, ir_next;
  logic [DATA_W-1:0] ext_opnd_reg, ext_opnd_next;
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic done_reg, done_next;

  iph_class_e cls;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_res;
  logic alu_carry;
  logic alu_zero;
  logic flush;
  logic [PC_W-1:0] fetch_addr;

  // reset release through two flops, the assert edge stays asynchronous
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  iph_clk_sel u_clk_sel ( // [RL2]
    .i_clk(i_clk),
    .i_rst_n(rst_n_reg),
    .i_clk_src(i_clk_src),
    .i_fast_irc_osc(i_fast_irc_osc),
    .i_slow_irc_osc(i_slow_irc_osc),
    .i_ext_xtal_osc(i_ext_xtal_osc),
    .o_sys_tick(tick)
  );

  assign cls = iph_class_f(ir_reg);
  // second word of an extended instruction supplies the operand
  assign alu_b = (exec_reg == EX_EXT2) ? ext_opnd_reg : ir_reg[IMM_HI:0];

  iph_alu u_alu ( // [RL10]
    .i_op(iph_op_f(ir_reg)),
    .i_a(acc_reg),
    .i_b(alu_b),
    .i_carry(carry_reg),
    .o_result(alu_res),
    .o_carry(alu_carry),
    .o_zero(alu_zero)
  );

  always_comb begin
    phase_next = phase_reg;
    exec_next = exec_reg;
    pc_next = pc_reg;
    pm_addr_next = pm_addr_reg;
    tgt_next = tgt_reg;
    pm_rd_next = 1'b0;
    boot_next = boot_reg;
    pf_next = pf_reg;
    pf_valid_next = pf_valid_reg;
    ir_next = ir_reg;
    ext_opnd_next = ext_opnd_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    done_next = 1'b0;
    flush = 1'b0;
    fetch_addr = pc_reg;
    if (boot_reg) begin
      // first fetch from the reset vector, inside the opening phase one
      pm_addr_next = RESET_VEC; // [RL12]
      pm_rd_next = 1'b1;
      pc_next = RESET_VEC + 14'h0001;
      boot_next = 1'b0;
    end else if (tick) begin
      case (phase_reg) // [RL1]
        PH_T1: begin
          phase_next = PH_T2;
          pf_next = i_pm_data; // [RL6]
          pf_valid_next = 1'b1;
        end
        PH_T2: begin
          phase_next = PH_T3;
          if (exec_reg == EX_RUN && cls == CL_BRANCH) begin
            tgt_next = ir_reg[TGT_HI:0]; // [RL9]
          end
        end
        PH_T3: begin
          phase_next = PH_T4;
        end
        PH_T4: begin
          phase_next = PH_T1; // [RL5]
          case (exec_reg) // [RL4]
            EX_RUN: begin
              case (cls)
                CL_BRANCH: begin
                  done_next = 1'b1;
                  flush = 1'b1; // [RL8]
                  fetch_addr = tgt_reg; // [RL9]
                end
                CL_SKIP: begin
                  done_next = 1'b1;
                  acc_next = alu_res;
                  carry_next = alu_carry;
                  flush = alu_zero; // [RL11]
                end
                CL_EXT: begin
                  done_next = 1'b0; // [RL7]
                end
                default: begin
                  done_next = 1'b1;
                  acc_next = alu_res;
                  carry_next = alu_carry;
                end
              endcase
            end
            EX_EXT2: begin
              done_next = 1'b1;
              acc_next = alu_res;
              carry_next = alu_carry;
            end
            default: begin
              done_next = 1'b0;
            end
          endcase
          if (flush) begin
            exec_next = EX_DUMMY; // [RL11]
          end else if (exec_reg == EX_RUN && cls == CL_EXT) begin
            exec_next = EX_EXT2; // [RL7]
            ext_opnd_next = pf_reg[IMM_HI:0];
          end else begin
            ir_next = pf_reg;
            exec_next = pf_valid_reg ? EX_RUN : EX_DUMMY;
          end
          pf_valid_next = 1'b0;
          // next phase one: fetch and bump the counter together
          pm_addr_next = fetch_addr; // [RL3]
          pm_rd_next = 1'b1;
          pc_next = fetch_addr + 14'h0001;
        end
        default: begin
          phase_next = PH_T1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      phase_reg <= PH_T1; // [RL12]
      exec_reg <= EX_DUMMY;
      pc_reg <= RESET_VEC;
      pm_addr_reg <= RESET_VEC;
      tgt_reg <= RESET_VEC;
      pm_rd_reg <= 1'b0;
      boot_reg <= 1'b1;
      pf_reg <= INSTR_RST;
      pf_valid_reg <= 1'b0;
      ir_reg <= INSTR_RST;
      ext_opnd_reg <= ACC_RST;
      acc_reg <= ACC_RST;
      carry_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      exec_reg <= exec_next;
      pc_reg <= pc_next;
      pm_addr_reg <= pm_addr_next;
      tgt_reg <= tgt_next;
      pm_rd_reg <= pm_rd_next;
      boot_reg <= boot_next;
      pf_reg <= pf_next;
      pf_valid_reg <= pf_valid_next;
      ir_reg <= ir_next;
      ext_opnd_reg <= ext_opnd_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      done_reg <= done_next;
    end
  end

  assign o_pm_addr = pm_addr_reg;
  assign o_pm_rd = pm_rd_reg;
  assign o_phase = phase_reg;
  assign o_pc = pc_reg;
  assign o_acc = acc_reg;
  assign o_carry = carry_reg;
  assign o_instr_done = done_reg;
  assign o_dummy = (exec_reg == EX_DUMMY);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_reg);

  phase_onehot_a: assert property ($onehot(phase_reg)) // [RL1]
    else $error("phase clocks overlap or vanish");

  phase_hold_a: assert property (!tick |=> $stable(phase_reg)) // [RL1]
    else $error("phase moved without a system tick");

  cycle_wrap_a: assert property ( // [RL5]
    tick && !boot_reg && phase_reg == PH_T4 |=> phase_reg == PH_T1 ##0
    pm_rd_reg)
    else $error("instruction cycle did not wrap to phase one");

  fetch_bump_a: assert property ( // [RL3]
    pm_rd_reg |-> phase_reg == PH_T1 &&
    pc_reg == PC_W'(pm_addr_reg + 14'h0001))
    else $error("fetch not paired with counter bump in phase one");

  fetch_overlap_a: assert property ( // [RL6]
    tick && !boot_reg && phase_reg == PH_T1 |=> pf_valid_reg &&
    pf_reg == $past(i_pm_data))
    else $error("prefetch not captured at end of phase one");

  done_phase_a: assert property ( // [RL4]
    done_reg |-> phase_reg == PH_T1 && $past(phase_reg) == PH_T4)
    else $error("instruction completed outside phase four");

  ext_two_a: assert property ( // [RL7]
    tick && !boot_reg && phase_reg == PH_T4 && exec_reg == EX_RUN &&
    cls == CL_EXT |=> exec_reg == EX_EXT2 && !done_reg)
    else $error("extended instruction did not take a second cycle");

  branch_target_a: assert property ( // [RL9]
    tick && !boot_reg && phase_reg == PH_T4 && exec_reg == EX_RUN &&
    cls == CL_BRANCH |=> exec_reg == EX_DUMMY && done_reg &&
    pm_addr_reg == $past(ir_reg[TGT_HI:0]))
    else $error("branch did not fetch its target into a dummy cycle");

  skip_dummy_a: assert property ( // [RL11]
    tick && !boot_reg && phase_reg == PH_T4 && exec_reg == EX_RUN &&
    cls == CL_SKIP && alu_zero |=> exec_reg == EX_DUMMY)
    else $error("taken skip kept the prefetched instruction");

  dummy_idle_a: assert property ( // [RL8]
    tick && !boot_reg && phase_reg == PH_T4 && exec_reg == EX_DUMMY
    |=> !done_reg && acc_reg == $past(acc_reg))
    else $error("dummy cycle completed or changed state");

  reset_start_a: assert property ( // [RL12]
    boot_reg |-> (phase_reg == PH_T1 && exec_reg == EX_DUMMY &&
    !pf_valid_reg) ##1 (pm_rd_reg && pm_addr_reg == RESET_VEC))
    else $error("pipeline not empty at phase one after reset");

  branch_c: cover property (tick && phase_reg == PH_T4 &&
    exec_reg == EX_RUN && cls == CL_BRANCH);
  skip_c: cover property (tick && phase_reg == PH_T4 &&
    exec_reg == EX_RUN && cls == CL_SKIP && alu_zero);
  ext_c: cover property (done_reg && $past(exec_reg) == EX_EXT2);
  normal_c: cover property (done_reg && $past(exec_reg) == EX_RUN &&
    $past(cls) == CL_NORM);

endmodule : iph_pipeline

// [iph_pm_model.sv]
// iph_pm_model: behavioural program memory facing the pipeline fetch port.
// assumes the bench loads mem directly; 64 words repeat over the address.
`timescale 1ns/10ps
module iph_pm_model (
  input wire logic i_clk,
  input wire logic i_pm_rd,
  input wire logic [iph_pkg::PC_W-1:0] i_pm_addr,
  input wire logic i_slow,
  output logic [iph_pkg::INSTR_W-1:0] o_pm_data
);
  import iph_pkg::*;
  logic [INSTR_W-1:0] mem [0:63];
  logic [5:0] addr_reg;
  logic [1:0] wait_cnt;
  initial begin
    o_pm_data = 16'hFFFF;
    wait_cnt = 2'h0;
  end
  // slow answers show the old word inverted, then the old word, then the new word
  always @(posedge i_clk) begin
    if (i_pm_rd) begin
      addr_reg <= i_pm_addr[5:0];
      if (i_slow) begin
        o_pm_data <= ~o_pm_data;
        wait_cnt <= 2'h2;
      end else begin
        o_pm_data <= mem[i_pm_addr[5:0]];
      end
    end else if (wait_cnt == 2'h1) begin
      o_pm_data <= mem[addr_reg];
      wait_cnt <= 2'h0;
    end else if (wait_cnt != 2'h0) begin
      o_pm_data <= ~o_pm_data;
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule : iph_pm_model

// [instruction_phase_pipeline_tb_top.sv]
// instruction_phase_pipeline_tb_top: random programs checked against a
// reference stepper, one run per select code 0 to 3, reset before each run.
// assumes the memory model shares i_clk with the pipeline.
`timescale 1ns/10ps
module instruction_phase_pipeline_tb_top;
  import iph_pkg::*;
  logic i_clk, i_resetn, fast, slow, xtal, pm_rd, carry, done, dummy;
  logic [1:0] src;
  logic [INSTR_W-1:0] pm_data;
  logic [PC_W-1:0] pm_addr, pc, ipc;
  logic [3:0] phase, ph_prev;
  logic [DATA_W-1:0] acc, iacc;
  logic [INSTR_W-1:0] bmem [0:63];
  logic ic, pen, first;
  int n_errors = 0, n_tests = 0, seed = 50, cyc = 0;
  int gap, dcnt, ndone, nrd, rgap, tp;

  iph_pipeline i_iph_pipeline (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_clk_src(src), .i_fast_irc_osc(fast), .i_slow_irc_osc(slow),
    .i_ext_xtal_osc(xtal), .i_pm_data(pm_data), .o_pm_addr(pm_addr),
    .o_pm_rd(pm_rd), .o_phase(phase), .o_pc(pc), .o_acc(acc),
    .o_carry(carry), .o_instr_done(done), .o_dummy(dummy));
  iph_pm_model i_iph_pm_model (.i_clk(i_clk), .i_pm_rd(pm_rd),
    .i_pm_addr(pm_addr), .i_slow(src[0]), .o_pm_data(pm_data));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  // oscillator periods 4, 8 and 6 cycles keep each level >= 2 cycles
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    fast <= (cyc % 4) < 2;
    slow <= (cyc % 8) < 4;
    xtal <= (cyc % 6) < 3;
  end

  task automatic chk_val(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input string nm, input int e, g);
    n_tests++;
    if (g != e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_cnt

  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  function automatic logic [8:0] alu_f(input logic [3:0] op,
    input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    s = {c, a};
    case (op)
      4'h0: s = {1'h0, a} + {1'h0, b};
      4'h1: s = {1'h0, a} + {1'h0, b} + {8'h00, c};
      4'h2: s = {1'h0, a} - {1'h0, b};
      4'h3: s = {1'h0, a} - {1'h0, b} - {8'h00, ~c};
      4'h4: s[7:0] = a & b;
      4'h5: s[7:0] = a | b;
      4'h6: s[7:0] = a ^ b;
      4'h7: s[7:0] = ~a;
      4'h8: s[7:0] = {a[6:0], a[7]};
      4'h9: s[7:0] = {a[0], a[7:1]};
      4'hA: s = {a, c};
      4'hB: s = {a[0], c, a[7:1]};
      4'hC: s[7:0] = a + 8'h01;
      4'hD: s[7:0] = a - 8'h01;
      4'hE: s[7:0] = b;
      default: s[7:0] = a;
    endcase
    // subtract keeps carry as no-borrow
    if (op == 4'h2 || op == 4'h3) s[8] = ~s[8];
    return s;
  endfunction : alu_f

  task automatic iss_step;
    logic [15:0] w;
    logic [8:0] r;
    int ext;
    w = bmem[ipc[5:0]];
    ext = 0;
    r = {ic, iacc};
    case (w[15:14])
      2'h0: begin
        r = alu_f(w[13:10], iacc, w[7:0], ic);
        ipc = ipc + 14'h1;
      end
      2'h1: begin
        r = alu_f(w[13:10], iacc, bmem[ipc[5:0] + 6'h1][7:0], ic);
        ipc = ipc + 14'h2;
        ext = 1;
      end
      2'h2: ipc = w[13:0];
      default: begin
        r = alu_f(w[13:10], iacc, w[7:0], ic);
        ipc = ipc + ((r[7:0] == 8'h00) ? 14'h2 : 14'h1);
      end
    endcase
    if (!first) begin
      chk_cnt("done_gap", 4 * tp * (1 + ext + int'(pen)), gap);
      chk_cnt("dummy_t3", tp * int'(pen), dcnt);
    end
    if (w[15:14] == 2'h2) begin
      chk_val("br_addr", {2'h0, ipc}, {2'h0, pm_addr});
      chk_val("br_pc", {2'h0, ipc + 14'h1}, {2'h0, pc});
    end
    pen = (w[15:14] == 2'h2) || (w[15:14] == 2'h3 && r[7:0] == 8'h00);
    iacc = r[7:0];
    ic = r[8];
    chk_val("acc", {8'h00, iacc}, {8'h00, acc});
    chk_val("carry", {15'h0, ic}, {15'h0, carry});
    first = 1'h0;
    gap = 0;
    dcnt = 0;
  endtask : iss_step

  // fixed head: taken skip over a branch, extended add, untaken skip
  task automatic load_prog;
    logic [31:0] r;
    bmem[0] = 16'hF800;
    bmem[1] = 16'h8005;
    bmem[2] = 16'h4000;
    bmem[3] = 16'h00FF;
    bmem[4] = 16'hF801;
    for (int i = 5; i < 64; i++) begin
      r = $random(seed);
      // no extended word after a skip: a discard would split the pair
      if (bmem[i-1][15:14] == 2'h1) r[15:14] = 2'h0;
      else if (bmem[i-1][15:14] == 2'h3 && r[15:14] == 2'h1) r[15:14] = 2'h0;
      if (r[15:14] == 2'h2) r[13:0] = {8'h00, r[5:0]};
      bmem[i] = r[15:0];
    end
    bmem[63] = 16'h8004;
    for (int i = 0; i < 64; i++) i_iph_pm_model.mem[i] = bmem[i];
  endtask : load_prog

  initial begin
    forever begin
      @(posedge i_clk);
      #1;
      if (i_resetn === 1'h1 && phase !== ph_prev)
        chk_val("phase", {12'h0, ph_prev[2:0], ph_prev[3]}, {12'h0, phase});
      ph_prev = phase;
      if (i_resetn === 1'h0) begin
        chk_val("rst", 16'h1800, {phase, dummy, pm_rd, pc[9:0]});
      end else begin
        gap++;
        rgap++;
        if (dummy === 1'h1 && phase === PH_T3) dcnt++;
        if (pm_rd === 1'h1) begin
          chk_val("rd_phase", {12'h0, PH_T1}, {12'h0, phase});
          chk_val("rd_pc", {2'h0, pm_addr + 14'h1}, {2'h0, pc});
          if (nrd == 0) chk_val("rd_first", 16'h0000, {2'h0, pm_addr});
          if (nrd >= 2) chk_cnt("fetch_gap", 4 * tp, rgap);
          nrd++;
          rgap = 0;
        end
        if (done === 1'h1) begin
          iss_step;
          ndone++;
        end
      end
    end
  end

  initial begin
    i_resetn = 1'h0;
    src = 2'h0;
    fast = 1'h0;
    slow = 1'h0;
    xtal = 1'h0;
    ph_prev = 4'h1;
    for (int s = 0; s < 4; s++) begin
      @(negedge i_clk);
      i_resetn = 1'h0;
      src = s[1:0];
      tp = (s == 1) ? 8 : (s == 2) ? 6 : 4;
      load_prog;
      ipc = 14'h0;
      iacc = 8'h00;
      ic = 1'h0;
      pen = 1'h0;
      first = 1'h1;
      ndone = 0;
      nrd = 0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'h1;
      for (int k = 0; k < 8000 && ndone < 40; k++) @(negedge i_clk);
      if (ndone < 40) begin
        n_errors++;
        break;
      end
    end
    finish_test;
  end
endmodule : instruction_phase_pipeline_tb_top
